/* common/pwm_regs.vh */
// Register offsets, field positions and reset values of the motor-control PWM block
`ifndef PWM_REGS_VH
`define PWM_REGS_VH

// Byte offsets on the register bus
`define OFS_TIME_BASE_CONTROL 8'h00
`define OFS_PERIOD_VALUE 8'h04
`define OFS_TIME_BASE_COUNT 8'h08
`define OFS_OUTPUT_CONFIG_ONE 8'h0C
`define OFS_OUTPUT_CONFIG_TWO 8'h10
`define OFS_DUTY_VALUE_CH1 8'h14
`define OFS_DUTY_VALUE_CH2 8'h18
`define OFS_DUTY_VALUE_CH3 8'h1C
`define OFS_OUTPUT_OVERRIDE_CONTROL 8'h20
`define OFS_IRQ_STATUS 8'h24
`define OFS_IRQ_MASK 8'h28

// time_base_control fields
`define TBC_MODE_LSB 0
`define TBC_DIR_BIT 14
`define TBC_ON_BIT 15

// time_base_mode encodings
`define MODE_FREE_RUN 2'h0
`define MODE_SINGLE_SHOT 2'h1
`define MODE_SINGLE_PULSE 2'h2
`define MODE_UP_DOWN 2'h3

// output_config_two fields
`define CFG2_UPDATE_BLOCK_BIT 0
`define CFG2_OVERRIDE_SYNC_BIT 1

// output_override_control: selects in 13:8, forced states in 5:0
`define OVD_SEL_LSB 8
`define OVD_STATE_LSB 0

// Interrupt status and mask bits
`define IRQ_PERIOD_BIT 0
`define IRQ_STOP_BIT 1

// Reset values
`define RST_PERIOD_VALUE 16'hFFFF
`define RST_DUTY_VALUE 16'h0000
`define RST_WORD 16'h0000

`endif

/* rtl/motor_pwm.v */
// Three-channel motor-control PWM generator with a classic Wishbone register slave
//
// What this block does
// - Edge-aligned: output active from count zero until count meets the duty value.
// - Edge-aligned: duty zero never active, duty above period always active.
// - Free-running and single-shot time base modes both give edge-aligned waveforms.
// - Up/down: duty match going down drives active, going up drives inactive.
// - Center-aligned: duty zero never active, duty equal to period always active.
// - Three independent 16-bit duty values, one per channel, set active time.
// - Duty bit zero picks a half-step edge, doubling period counter resolution.
// - Each channel has a writable duty buffer apart from its active compare value.
// - Edge-aligned reload at period match; continuous reload while off and not blocked.
// - Up/down reload when count is zero and turns up, and whenever off.
// - Independent pair: no dead time, both pins may be active together.
// - Independent pair: one generator feeds both pins, each pin overridable.
// - Mode 10 is single pulse, edge-aligned, pins active once the time base starts.
// - Single pulse: duty match ends pulse; period match clears count and enable, sets stop interrupt status.
// - Override upper six bits select overridden pins, lower six give forced states.
// - Complementary: low side forced active outputs complement of its high side.
// - Override sync: apply at count zero, or zero and period match when centered.
//
// The placing of the registers and the Wishbone register port were left to the implementer.
`include "pwm_regs.vh"

module motor_pwm #(
    parameter CHANNELS = 3,
    parameter DUTY_W = 16
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Wishbone classic slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // Power stage pin pairs, active high
    output reg [CHANNELS-1:0] high_side_pin,
    output reg [CHANNELS-1:0] low_side_pin,
    // Interrupt request, level
    output reg irq
);

    // Software-visible registers
    reg time_base_on_q;
    reg [1:0] time_base_mode_q;
    reg [DUTY_W-1:0] period_value_q;
    reg [CHANNELS-1:0] pair_independent_sel_q;
    reg update_block_q;
    reg override_sync_sel_q;
    reg [DUTY_W-1:0] duty_buf_q [0:CHANNELS-1];
    reg [15:0] output_override_control_q;
    reg [1:0] irq_status_q;
    reg [1:0] irq_mask_q;

    // Time base state
    reg [DUTY_W-1:0] time_base_count_q;
    reg half_step_q;
    reg count_direction_flag_q;
    reg [DUTY_W-1:0] duty_act_q [0:CHANNELS-1];
    reg [15:0] override_eff_q;

    // Bus decode
    wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire bus_wr = bus_req & wb_we_i;

    // Mode decode
    wire up_down = (time_base_mode_q == `MODE_UP_DOWN);
    wire one_run = (time_base_mode_q == `MODE_SINGLE_SHOT) |
                   (time_base_mode_q == `MODE_SINGLE_PULSE);
    wire period_hit = (time_base_count_q == period_value_q);
    wire count_zero = (time_base_count_q == {DUTY_W{1'b0}});

    // End of a one-run period: counter stops and the enable is cleared by hardware
    wire run_end = time_base_on_q & half_step_q & period_hit & one_run & ~up_down;
    wire period_event = time_base_on_q & half_step_q & period_hit;

    // Byte-lane merge for a 16-bit register in the low half of the word
    function [15:0] merge16;
        input [15:0] old;
        input [31:0] data;
        input [3:0] sel;
        begin
            merge16 = old;
            if (sel[0]) begin
                merge16[7:0] = data[7:0];
            end
            if (sel[1]) begin
                merge16[15:8] = data[15:8];
            end
        end
    endfunction

    wire [15:0] ctl_word = {time_base_on_q, count_direction_flag_q, 12'h000, time_base_mode_q};
    wire [15:0] ctl_new = merge16(ctl_word, wb_dat_i, wb_sel_i);

    // Time base control; a software write in the same cycle as a hardware stop wins
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            time_base_on_q <= 1'b0;
            time_base_mode_q <= `MODE_FREE_RUN;
        end else if (bus_wr && wb_adr_i == `OFS_TIME_BASE_CONTROL) begin
            time_base_on_q <= ctl_new[`TBC_ON_BIT];
            time_base_mode_q <= ctl_new[`TBC_MODE_LSB+1:`TBC_MODE_LSB];
        end else if (run_end) begin
            time_base_on_q <= 1'b0;
        end
    end

    // Plain configuration registers
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            period_value_q <= `RST_PERIOD_VALUE;
            pair_independent_sel_q <= {CHANNELS{1'b0}};
            update_block_q <= 1'b0;
            override_sync_sel_q <= 1'b0;
            output_override_control_q <= `RST_WORD;
            irq_mask_q <= 2'h0;
        end else if (bus_wr) begin
            case (wb_adr_i)
                `OFS_PERIOD_VALUE: begin
                    period_value_q <= merge16(period_value_q, wb_dat_i, wb_sel_i);
                end
                `OFS_OUTPUT_CONFIG_ONE: begin
                    if (wb_sel_i[0]) begin
                        pair_independent_sel_q <= wb_dat_i[CHANNELS-1:0];
                    end
                end
                `OFS_OUTPUT_CONFIG_TWO: begin
                    if (wb_sel_i[0]) begin
                        update_block_q <= wb_dat_i[`CFG2_UPDATE_BLOCK_BIT];
                        override_sync_sel_q <= wb_dat_i[`CFG2_OVERRIDE_SYNC_BIT];
                    end
                end
                `OFS_OUTPUT_OVERRIDE_CONTROL: begin
                    output_override_control_q <= merge16(output_override_control_q,
                                                         wb_dat_i, wb_sel_i);
                end
                `OFS_IRQ_MASK: begin
                    if (wb_sel_i[0]) begin
                        irq_mask_q <= wb_dat_i[1:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Time base counter; half_step_q is the extra bit that doubles duty resolution
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            time_base_count_q <= {DUTY_W{1'b0}};
            half_step_q <= 1'b0;
            count_direction_flag_q <= 1'b0;
        end else if (!time_base_on_q || run_end) begin
            // Idle or finished: park at zero counting up, ready for the next start
            time_base_count_q <= {DUTY_W{1'b0}};
            half_step_q <= 1'b0;
            count_direction_flag_q <= 1'b0;
        end else begin
            half_step_q <= ~half_step_q;
            if (half_step_q) begin
                if (!up_down) begin
                    if (period_hit) begin
                        time_base_count_q <= {DUTY_W{1'b0}};
                    end else begin
                        time_base_count_q <= time_base_count_q + 1'b1;
                    end
                end else if (!count_direction_flag_q) begin
                    if (period_hit && !count_zero) begin
                        count_direction_flag_q <= 1'b1;
                        time_base_count_q <= time_base_count_q - 1'b1;
                    end else if (!period_hit) begin
                        time_base_count_q <= time_base_count_q + 1'b1;
                    end
                end else begin
                    if (count_zero) begin
                        count_direction_flag_q <= 1'b0;
                        time_base_count_q <= time_base_count_q + 1'b1;
                    end else begin
                        time_base_count_q <= time_base_count_q - 1'b1;
                    end
                end
            end
        end
    end

    // When the active compare values take the buffered duty values
    wire load_edge = (time_base_on_q & period_event & ~up_down) |
                     (~time_base_on_q & ~update_block_q);
    wire load_center = (time_base_on_q & half_step_q & count_direction_flag_q & count_zero) |
                       ~time_base_on_q;
    wire load_duty = up_down ? load_center : load_edge;

    // Position within the period in half steps
    wire [DUTY_W:0] pos = {time_base_count_q, half_step_q};

    // Override synchronisation points: the first half step of count zero, and for
    // up/down also the first half step at the period; idle time base takes it at once
    wire sync_pt = ~time_base_on_q | (~half_step_q & count_zero) |
                   (up_down & ~half_step_q & period_hit);
    wire ovd_take = ~override_sync_sel_q | sync_pt;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            override_eff_q <= `RST_WORD;
        end else if (ovd_take) begin
            override_eff_q <= output_override_control_q;
        end
    end

    // Per-channel duty buffer, active compare and pin logic
    reg [CHANNELS-1:0] wave;
    reg [CHANNELS-1:0] high_d;
    reg [CHANNELS-1:0] low_d;
    reg ovd_h;
    reg ovd_l;
    reg st_h;
    reg st_l;
    integer i;
    integer j;

    // Compare units; the waveform is a level derived from the position so a late
    // duty reload can never leave a pin stuck in the wrong state for a period
    always @* begin
        wave = {CHANNELS{1'b0}};
        for (i = 0; i < CHANNELS; i = i + 1) begin
            if (!time_base_on_q) begin
                wave[i] = 1'b0;
            end else if (up_down) begin
                if (duty_act_q[i] == {DUTY_W{1'b0}}) begin
                    wave[i] = 1'b0;
                end else if (duty_act_q[i] == period_value_q) begin
                    wave[i] = 1'b1;
                end else begin
                    // Active below the duty: set on the down match, cleared on the up one
                    wave[i] = (pos < {1'b0, duty_act_q[i]});
                end
            end else begin
                // Free-run, single-shot and single pulse share the edge-aligned form
                if (duty_act_q[i] == {DUTY_W{1'b0}}) begin
                    wave[i] = 1'b0;
                end else if (duty_act_q[i] > period_value_q) begin
                    wave[i] = 1'b1;
                end else begin
                    wave[i] = (pos < {1'b0, duty_act_q[i]});
                end
            end
        end
    end

    // Pin mapping; override bits are ordered {3H,3L,2H,2L,1H,1L}
    always @* begin
        high_d = {CHANNELS{1'b0}};
        low_d = {CHANNELS{1'b0}};
        ovd_h = 1'b0;
        ovd_l = 1'b0;
        st_h = 1'b0;
        st_l = 1'b0;
        for (j = 0; j < CHANNELS; j = j + 1) begin
            ovd_h = override_eff_q[`OVD_SEL_LSB + 2*j + 1];
            ovd_l = override_eff_q[`OVD_SEL_LSB + 2*j];
            st_h = override_eff_q[`OVD_STATE_LSB + 2*j + 1];
            st_l = override_eff_q[`OVD_STATE_LSB + 2*j];
            high_d[j] = ovd_h ? st_h : wave[j];
            if (pair_independent_sel_q[j]) begin
                // Same generator on both pins, no interlock between them
                low_d[j] = ovd_l ? st_l : wave[j];
            end else if (ovd_l && st_l) begin
                low_d[j] = ~high_d[j];
            end else if (ovd_l) begin
                low_d[j] = 1'b0;
            end else begin
                low_d[j] = ~high_d[j];
            end
        end
    end

    // Duty buffers take bus writes; active copies reload only at safe points
    genvar g;
    generate
        for (g = 0; g < CHANNELS; g = g + 1) begin : ch
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    duty_buf_q[g] <= `RST_DUTY_VALUE;
                end else if (bus_wr && wb_adr_i == (`OFS_DUTY_VALUE_CH1 + 8'h04 * g)) begin
                    duty_buf_q[g] <= merge16(duty_buf_q[g], wb_dat_i, wb_sel_i);
                end
            end

            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    duty_act_q[g] <= `RST_DUTY_VALUE;
                end else if (load_duty) begin
                    duty_act_q[g] <= duty_buf_q[g];
                end
            end
        end
    endgenerate

    // Registered pins; dead time is not generated in this block
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            high_side_pin <= {CHANNELS{1'b0}};
            low_side_pin <= {CHANNELS{1'b0}};
        end else begin
            high_side_pin <= high_d;
            low_side_pin <= low_d;
        end
    end

    // Sticky interrupt status, write one to clear; a new event beats the clear
    wire [1:0] irq_set = {run_end, period_event};
    reg [1:0] irq_clr;
    always @* begin
        irq_clr = 2'h0;
        if (bus_wr && wb_adr_i == `OFS_IRQ_STATUS && wb_sel_i[0]) begin
            irq_clr = wb_dat_i[1:0];
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_status_q <= 2'h0;
            irq <= 1'b0;
        end else begin
            irq_status_q <= (irq_status_q & ~irq_clr) | irq_set;
            irq <= |(((irq_status_q & ~irq_clr) | irq_set) & irq_mask_q);
        end
    end

    // Read mux; unmapped addresses read zero and are still acknowledged
    reg [31:0] rd_data;
    always @* begin
        rd_data = 32'h00000000;
        case (wb_adr_i)
            `OFS_TIME_BASE_CONTROL: rd_data = {16'h0000, ctl_word};
            `OFS_PERIOD_VALUE: rd_data = {16'h0000, period_value_q};
            `OFS_TIME_BASE_COUNT: rd_data = {16'h0000, time_base_count_q};
            `OFS_OUTPUT_CONFIG_ONE: rd_data = {29'h00000000, pair_independent_sel_q};
            `OFS_OUTPUT_CONFIG_TWO: rd_data = {30'h00000000, override_sync_sel_q,
                                               update_block_q};
            `OFS_DUTY_VALUE_CH1: rd_data = {16'h0000, duty_buf_q[0]};
            `OFS_DUTY_VALUE_CH2: rd_data = {16'h0000, duty_buf_q[1]};
            `OFS_DUTY_VALUE_CH3: rd_data = {16'h0000, duty_buf_q[2]};
            `OFS_OUTPUT_OVERRIDE_CONTROL: rd_data = {16'h0000, output_override_control_q};
            `OFS_IRQ_STATUS: rd_data = {30'h00000000, irq_status_q};
            `OFS_IRQ_MASK: rd_data = {30'h00000000, irq_mask_q};
            default: rd_data = 32'h00000000;
        endcase
    end

    // One-wait-state answer; ack drops the cycle after it is given
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= bus_req;
            if (bus_req && !wb_we_i) begin
                wb_dat_o <= rd_data;
            end
        end
    end

endmodule

/* verif/motor_pwm_asserts.sv */
// Port-level concurrent checks of the motor-control PWM block
`include "pwm_regs.vh"
module motor_pwm_asserts #(
    parameter CHANNELS = 3,
    parameter DUTY_W = 16
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Wishbone classic slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    // Pins and interrupt
    input wire [CHANNELS-1:0] high_side_pin,
    input wire [CHANNELS-1:0] low_side_pin,
    input wire irq
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] shadow_q [16];
    wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire [3:0] idx = wb_adr_i[5:2];
    wire full_reg = (wb_adr_i == `OFS_PERIOD_VALUE) || (wb_adr_i >= `OFS_DUTY_VALUE_CH1
        && wb_adr_i <= `OFS_DUTY_VALUE_CH3);

    // Shadow of what software wrote, so each output can be tied to its cause
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 16; i++) shadow_q[i] <= (i == 1) ? 16'hFFFF : 16'h0000;
        end else if (take && wb_we_i && wb_adr_i[7:6] == 2'h0) begin
            if (wb_sel_i[0]) shadow_q[idx][7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) shadow_q[idx][15:8] <= wb_dat_i[15:8];
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_answers: assert property (take |=> wb_ack_o)
        else $error("request not answered in one cycle");
    a_ack_caused: assert property (wb_ack_o |-> $past(take))
        else $error("ack without a request");
    a_duty_readback: assert property (
        take && !wb_we_i && full_reg |=> wb_dat_o == {16'h0000, shadow_q[$past(idx)]})
        else $error("buffer readback differs from last write");
    a_unmapped_zero: assert property (take && !wb_we_i && wb_adr_i >= 8'h2C |=> wb_dat_o == 0)
        else $error("unmapped read not zero");
    a_comp_pair: assert property (
        shadow_q[3][2:0] == 3'h0 && shadow_q[8][13:8] == 6'h00 && !shadow_q[4][1]
        |=> low_side_pin == ~high_side_pin)
        else $error("low side not complement of high side");
    a_force_high: assert property (
        !shadow_q[4][1] && shadow_q[8][9] && $stable(shadow_q[8])
        |=> high_side_pin[0] == $past(shadow_q[8][1]))
        else $error("high side override state not applied");
    a_force_indep_low: assert property (
        shadow_q[3][0] && !shadow_q[4][1] && shadow_q[8][8] && $stable(shadow_q[8])
        && $stable(shadow_q[3]) |=> low_side_pin[0] == $past(shadow_q[8][0]))
        else $error("independent low side override not applied");
    a_irq_masked: assert property (
        irq |-> shadow_q[10][1:0] != 2'h0 || $past(shadow_q[10][1:0]) != 2'h0)
        else $error("interrupt raised while fully masked");
endmodule

/* verif/power_stage_model.sv */
// Behavioural power stage that watches the PWM pin pairs
module power_stage_model #(
    parameter CHANNELS = 3
) (
    // Clock and counter clear
    input wire clk,
    input wire clr,
    // Pin pairs driven by the PWM block
    input wire [CHANNELS-1:0] high_side_pin,
    input wire [CHANNELS-1:0] low_side_pin,
    // Observations for the bench
    output logic [15:0] on_cnt [CHANNELS],
    output logic [CHANNELS-1:0] both_on
);
    timeunit 1ns;
    timeprecision 1ns;

    // Latch on the rising edge as a gate driver would; overlap is shoot-through
    always @(posedge clk) begin
        for (int i = 0; i < CHANNELS; i++) begin
            if (clr) begin
                on_cnt[i] <= 16'h0000;
                both_on[i] <= 1'b0;
            end else begin
                on_cnt[i] <= on_cnt[i] + {15'h0000, high_side_pin[i]};
                both_on[i] <= both_on[i] | (high_side_pin[i] & low_side_pin[i]);
            end
        end
    end
endmodule

/* verif/motor_control_pwm_outputs_bench.sv */
// Self-checking bench for the motor-control PWM block
`include "pwm_regs.vh"
module motor_control_pwm_outputs_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic clr = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h3;
    logic [31:0] wdat = 32'h00000000;
    logic [31:0] rdat;
    logic ack;
    logic irq;
    logic [2:0] hp;
    logic [2:0] lp;
    logic [15:0] on_cnt [3];
    logic [2:0] both_on;
    int miscompares = 0;
    int n_compared = 0;

    motor_pwm #(.CHANNELS(3), .DUTY_W(16)) dut_u (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .high_side_pin(hp), .low_side_pin(lp), .irq(irq));
    power_stage_model #(.CHANNELS(3)) stage_u (.clk(clk), .clr(clr), .high_side_pin(hp),
        .low_side_pin(lp), .on_cnt(on_cnt), .both_on(both_on));

    // Compare one value and keep score
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t ns: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // One classic cycle, held until ack is sampled high, then a idle cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d,
        output logic [15:0] q);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {16'h0000, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1);
        q = rdat[15:0];
        chk(n[15:0], 16'h0002, "bus latency");
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [15:0] q;
        wb(1'b1, a, d, q);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [15:0] exp, input string what);
        logic [15:0] q;
        wb(1'b0, a, 16'h0000, q);
        chk(q, exp, what);
    endtask
    // Clear the stage counters; a window of whole periods makes counts phase-free
    task automatic zero();
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
    endtask
    task automatic meas(input int n);
        zero();
        repeat (n + 1) @(posedge clk);
    endtask

    task automatic t_reset();
        rdc(`OFS_PERIOD_VALUE, 16'hFFFF, "period reset");
        rdc(`OFS_DUTY_VALUE_CH3, 16'h0000, "duty reset");
        rdc(8'h30, 16'h0000, "unmapped read");
        chk({10'h000, hp, lp}, 16'h0007, "idle pins");
        $display("test reset done");
    endtask
    task automatic t_edge();
        wr(`OFS_PERIOD_VALUE, 16'h0007);
        wr(`OFS_DUTY_VALUE_CH1, 16'h0003);
        wr(`OFS_DUTY_VALUE_CH2, 16'h0000);
        wr(`OFS_DUTY_VALUE_CH3, 16'h0009);
        wr(`OFS_TIME_BASE_CONTROL, 16'h8000);
        repeat (40) @(posedge clk);
        meas(16);
        chk(on_cnt[0], 16'h0003, "odd duty width");
        chk(on_cnt[1], 16'h0000, "zero duty");
        chk(on_cnt[2], 16'h0010, "duty above period");
        chk({13'h0000, both_on}, 16'h0000, "pair overlap");
        wr(`OFS_DUTY_VALUE_CH1, 16'h0006);
        rdc(`OFS_DUTY_VALUE_CH1, 16'h0006, "buffer readback");
        repeat (40) @(posedge clk);
        meas(16);
        chk(on_cnt[0], 16'h0006, "reloaded duty");
        wr(`OFS_TIME_BASE_CONTROL, 16'h0000);
        $display("test edge done");
    endtask
    task automatic t_pulse();
        logic [15:0] q;
        wr(`OFS_DUTY_VALUE_CH1, 16'h0004);
        wr(`OFS_IRQ_MASK, 16'h0002);
        for (int m = 1; m < 3; m++) begin
            wr(`OFS_IRQ_STATUS, 16'h0003);
            zero();
            wr(`OFS_TIME_BASE_CONTROL, 16'h8000 | m[15:0]);
            repeat (40) @(posedge clk);
            chk(on_cnt[0], 16'h0004, "single run width");
            rdc(`OFS_TIME_BASE_CONTROL, m[15:0], "enable cleared");
            wb(1'b0, `OFS_IRQ_STATUS, 16'h0000, q);
            chk(q & 16'h0002, 16'h0002, "run end status");
            chk({15'h0000, irq}, 16'h0001, "irq raised");
            wr(`OFS_IRQ_MASK, 16'h0000);
            chk({15'h0000, irq}, 16'h0000, "irq masked");
            wr(`OFS_IRQ_MASK, 16'h0002);
            chk({15'h0000, irq}, 16'h0001, "irq unmasked");
            wr(`OFS_IRQ_STATUS, 16'h0003);
            chk({15'h0000, irq}, 16'h0000, "irq cleared");
        end
        $display("test pulse done");
    endtask
    task automatic t_center();
        wr(`OFS_PERIOD_VALUE, 16'h0004);
        wr(`OFS_DUTY_VALUE_CH1, 16'h0000);
        wr(`OFS_DUTY_VALUE_CH2, 16'h0004);
        wr(`OFS_DUTY_VALUE_CH3, 16'h0002);
        wr(`OFS_TIME_BASE_CONTROL, 16'h8003);
        repeat (40) @(posedge clk);
        meas(16);
        chk(on_cnt[0], 16'h0000, "center zero duty");
        chk(on_cnt[1], 16'h0010, "center full duty");
        chk({15'h0000, on_cnt[2] > 0 && on_cnt[2] < 16}, 16'h0001, "center part");
        wr(`OFS_TIME_BASE_CONTROL, 16'h0000);
        $display("test center done");
    endtask
    task automatic t_override();
        wr(`OFS_OUTPUT_CONFIG_ONE, 16'h0001);
        wr(`OFS_OUTPUT_OVERRIDE_CONTROL, 16'h0F0F);
        @(posedge clk);
        chk({10'h000, hp, lp}, 16'h001D, "forced active");
        wr(`OFS_OUTPUT_OVERRIDE_CONTROL, 16'h0300);
        @(posedge clk);
        chk({10'h000, hp, lp}, 16'h0006, "forced inactive");
        wr(`OFS_OUTPUT_OVERRIDE_CONTROL, 16'h0000);
        wr(`OFS_OUTPUT_CONFIG_ONE, 16'h0000);
        $display("test override done");
    endtask
    task automatic t_sync();
        wr(`OFS_PERIOD_VALUE, 16'h0007);
        wr(`OFS_OUTPUT_CONFIG_TWO, 16'h0002);
        wr(`OFS_TIME_BASE_CONTROL, 16'h8000);
        // Written mid-period, so it must wait for the next count zero
        wr(`OFS_OUTPUT_OVERRIDE_CONTROL, 16'h0202);
        @(posedge clk);
        chk({15'h0000, hp[0]}, 16'h0000, "override held back");
        repeat (16) @(posedge clk);
        chk({14'h0000, hp[0], lp[0]}, 16'h0002, "override at zero");
        wr(`OFS_OUTPUT_OVERRIDE_CONTROL, 16'h0000);
        wr(`OFS_TIME_BASE_CONTROL, 16'h0000);
        wr(`OFS_OUTPUT_CONFIG_TWO, 16'h0001);
        wr(`OFS_DUTY_VALUE_CH1, 16'h0006);
        zero();
        wr(`OFS_TIME_BASE_CONTROL, 16'h8000);
        repeat (15) @(posedge clk);
        chk(on_cnt[0], 16'h0000, "reload blocked while off");
        meas(16);
        chk(on_cnt[0], 16'h0006, "reload at period match");
        wr(`OFS_TIME_BASE_CONTROL, 16'h0000);
        wr(`OFS_OUTPUT_CONFIG_TWO, 16'h0000);
        $display("test sync done");
    endtask

    // Print the counts and the verdict, then stop
    task automatic give_verdict();
        $display("compared %0d, mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        forever #50 clk = ~clk;
    end
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_edge();
        t_pulse();
        t_center();
        t_override();
        t_sync();
        give_verdict();
    end
    // Watchdog: the tests need well under 2000 clocks
    initial begin
        #(100 * 5000);
        miscompares++;
        $display("[FAIL] %0t ns: watchdog expired", $time);
        give_verdict();
    end
endmodule

bind motor_pwm motor_pwm_asserts #(.CHANNELS(CHANNELS), .DUTY_W(DUTY_W)) checker_u (
    .clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .high_side_pin(high_side_pin), .low_side_pin(low_side_pin),
    .irq(irq));
